// ---- include/mtd_reg_map.vh ----
`ifndef MTD_REG_MAP_VH
`define MTD_REG_MAP_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define MTD_IDX_TONE_DC     16'h61b8
`define MTD_IDX_MODEM_TEST  16'h61b9
`define MTD_IDX_Q_OVERRIDE  16'h61ba
`define MTD_IDX_DAC_SOURCE  16'h61bc

// ****************************************************************
// Reset values and field positions
// ****************************************************************
`define MTD_RST_TONE_DC     8'h75
`define MTD_RST_MODEM_TEST  5'h08
`define MTD_RST_Q_OVERRIDE  7'h00
`define MTD_RST_DAC_SOURCE  3'h0
`define MTD_TONE_HI         7
`define MTD_TONE_LO         4
`define MTD_WIN_HI          3
`define MTD_WIN_LO          2
`define MTD_DCOP_HI         1
`define MTD_DCOP_LO         0
`define MTD_BIT_TONE_ONLY   4
`define MTD_BIT_RAMP        3
`define MTD_BIT_OBSERVE     2
`define MTD_BIT_MODSEL      1

// ****************************************************************
// Enumerations
// ****************************************************************
`define MTD_DC_PASS         2'h0
`define MTD_DC_FREEZE       2'h2
`define MTD_SRC_MOD         3'h0
`define MTD_SRC_OVR         3'h1
`define MTD_SRC_ADC         3'h2
`define MTD_SRC_FILT        3'h3
`define MTD_SRC_CORDIC      3'h4
`define MTD_SRC_RSSI        3'h5
`define MTD_RESP_OKAY       2'h0
`define MTD_RESP_SLVERR     2'h2

// ****************************************************************
// Slice select and DC window
// ****************************************************************
`define MTD_SLICE_MIN       7'h06
`define MTD_SLICE_MAX       7'h0b
`define MTD_WIN_BASE_LOG2   5

// ****************************************************************
// Tone phase steps for a 16-bit accumulator at 40 MHz
// ****************************************************************
`define MTD_STEP_6M         16'h2666
`define MTD_STEP_4M         16'h199a
`define MTD_STEP_3M         16'h1333
`define MTD_STEP_2M         16'h0ccd
`define MTD_STEP_1M         16'h0666
`define MTD_STEP_500K       16'h0333
`define MTD_STEP_4K         16'h0007

// ****************************************************************
// Ramp timing
// ****************************************************************
`define MTD_RAMP_STEP_NS    100
`define MTD_CLK_PERIOD_NS   25
`define MTD_RAMP_FULL       5'h10

`endif

// ---- hw/mtd_dc_blocker.v ----
`timescale 1ns/10ps
`include "mtd_reg_map.vh"

module mtd_dc_blocker (
  input  wire              clock,
  input  wire              arst_n,
  input  wire [1:0]        dc_blocker_op,
  input  wire [1:0]        dc_window_length,
  input  wire              sync_found,
  input  wire signed [9:0] in_data,
  input  wire              in_valid,
  output reg  signed [9:0] out_data,
  output reg               out_valid
);

  reg signed [17:0] acc_q;
  reg        [7:0]  cnt_q;
  reg signed [9:0]  est_q;
  wire       [7:0]  last_w;
  wire              frozen_w;
  wire signed [17:0] sum_w;
  wire signed [17:0] shifted_w;
  wire signed [10:0] diff_w;

  // Window of 32 << code samples; count runs 0..N-1
  assign last_w    = (8'h20 << dc_window_length) - 8'h01;
  assign sum_w     = acc_q + {{8{in_data[9]}}, in_data};
  assign shifted_w = sum_w >>> (`MTD_WIN_BASE_LOG2 + dc_window_length);
  // In freeze mode only, estimates hold while a frame is locked, so the payload sees a stable offset
  assign frozen_w  = (dc_blocker_op == `MTD_DC_FREEZE) && sync_found;
  assign diff_w    = {in_data[9], in_data} - {est_q[9], est_q};

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_q <= 18'sh0_0000;
      cnt_q <= 8'h00;
      est_q <= 10'sh000;
    end
    else if (dc_blocker_op == `MTD_DC_PASS)
    begin
      acc_q <= 18'sh0_0000;
      cnt_q <= 8'h00;
      est_q <= 10'sh000;
    end
    else if (in_valid && !frozen_w)
    begin
      if (cnt_q >= last_w)
      begin
        // Dump takes the current sample too, so every window averages exactly N
        est_q <= shifted_w[9:0];
        acc_q <= 18'sh0_0000;
        cnt_q <= 8'h00;
      end
      else
      begin
        acc_q <= sum_w;
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_data  <= 10'sh000;
      out_valid <= 1'b0;
    end
    else
    begin
      out_valid <= in_valid;
      if (dc_blocker_op == `MTD_DC_PASS)
        out_data <= in_data;
      else if (diff_w > 11'sh1ff)
        out_data <= 10'sh1ff;
      else if (diff_w < -11'sh200)
        out_data <= -10'sh200;
      else
        out_data <= diff_w[9:0];
    end
  end

endmodule // mtd_dc_blocker

// ---- hw/mtd_tone_gen.v ----
`timescale 1ns/10ps
`include "mtd_reg_map.vh"

module mtd_tone_gen (
  input  wire       clock,
  input  wire       arst_n,
  input  wire [3:0] step_code,
  output reg  [6:0] tone_i,
  output reg  [6:0] tone_q
);

  reg  [15:0] phase_q;
  reg  [15:0] step_w;

  // Quarter-wave sine, amplitude 63, 64 points per turn
  function [6:0] sine7;
    input [5:0] p;
    reg   [4:0] k;
    reg   [6:0] m;
    begin
      k = p[4] ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
      case (k)
        5'd0:    m = 7'd0;
        5'd1:    m = 7'd6;
        5'd2:    m = 7'd12;
        5'd3:    m = 7'd18;
        5'd4:    m = 7'd24;
        5'd5:    m = 7'd30;
        5'd6:    m = 7'd35;
        5'd7:    m = 7'd40;
        5'd8:    m = 7'd45;
        5'd9:    m = 7'd49;
        5'd10:   m = 7'd53;
        5'd11:   m = 7'd56;
        5'd12:   m = 7'd58;
        5'd13:   m = 7'd60;
        5'd14:   m = 7'd62;
        default: m = 7'd63;
      endcase
      sine7 = p[5] ? (7'h00 - m) : m;
    end
  endfunction

  always @*
  begin
    case (step_code)
      4'h0:    step_w = 16'h0000 - `MTD_STEP_6M;
      4'h1:    step_w = 16'h0000 - `MTD_STEP_4M;
      4'h2:    step_w = 16'h0000 - `MTD_STEP_3M;
      4'h3:    step_w = 16'h0000 - `MTD_STEP_2M;
      4'h4:    step_w = 16'h0000 - `MTD_STEP_1M;
      4'h5:    step_w = 16'h0000 - `MTD_STEP_500K;
      4'h6:    step_w = 16'h0000 - `MTD_STEP_4K;
      4'h8:    step_w = `MTD_STEP_4K;
      4'h9:    step_w = `MTD_STEP_500K;
      4'ha:    step_w = `MTD_STEP_1M;
      4'hb:    step_w = `MTD_STEP_2M;
      4'hc:    step_w = `MTD_STEP_3M;
      4'hd:    step_w = `MTD_STEP_4M;
      4'he:    step_w = `MTD_STEP_6M;
      default: step_w = 16'h0000;
    endcase
  end

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_q <= 16'h0000;
      tone_i  <= 7'h00;
      tone_q  <= 7'h00;
    end
    else
    begin
      phase_q <= phase_q + step_w;
      tone_i  <= sine7(phase_q[15:10] + 6'h10);
      tone_q  <= sine7(phase_q[15:10]);
    end
  end

endmodule // mtd_tone_gen

// ---- hw/mtd_top.v ----
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "mtd_reg_map.vh"

module mtd_top (
  input  wire        clock,
  input  wire        arst_n,
  input  wire [17:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [17:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [9:0]  rx_i_in,
  input  wire [9:0]  rx_q_in,
  input  wire        rx_in_valid,
  input  wire        rx_sync_found,
  output wire [9:0]  rx_i_out,
  output wire [9:0]  rx_q_out,
  output wire        rx_out_valid,
  output reg         mod_phase_reverse,
  input  wire [6:0]  mod_i_in,
  input  wire [6:0]  mod_q_in,
  input  wire        tx_active,
  input  wire [11:0] adc_q_word,
  input  wire [11:0] filt_q_word,
  input  wire [11:0] cordic_word,
  input  wire [6:0]  rssi_word,
  output reg  [6:0]  dac_i_out,
  output reg  [6:0]  dac_q_out,
  input  wire        rx_pkt_bit,
  input  wire        tx_pkt_bit,
  output reg  [1:0]  gpio_observe_out,
  output reg         gpio_observe_oe
);

  localparam RAMP_CYC = (`MTD_RAMP_STEP_NS + `MTD_CLK_PERIOD_NS - 1) / `MTD_CLK_PERIOD_NS;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Seven-bit window of a source word; lsb = sel - 6, out of range gives zero
  function [6:0] slice7;
    input [11:0] word;
    input [6:0]  sel;
    reg   [11:0] sh;
    begin
      sh = word >> (sel - `MTD_SLICE_MIN);
      if (sel >= `MTD_SLICE_MIN && sel <= `MTD_SLICE_MAX)
        slice7 = sh[6:0];
      else
        slice7 = 7'h00;
    end
  endfunction

  // Saturating signed seven-bit sum
  function [6:0] sat_add7;
    input [6:0] a;
    input [6:0] b;
    reg   [7:0] s;
    begin
      s = {a[6], a} + {b[6], b};
      if (s[7] != s[6])
        sat_add7 = s[7] ? 7'h40 : 7'h3f;
      else
        sat_add7 = s[6:0];
    end
  endfunction

  // Scale a signed sample by ramp level 0..16
  function [6:0] scale7;
    input [6:0] a;
    input [4:0] lvl;
    reg signed [12:0] p;
    begin
      p = $signed(a) * $signed({1'b0, lvl});
      scale7 = p[10:4];
    end
  endfunction

  function [31:0] read_value;
    input [15:0] idx;
    input [7:0]  tone_dc;
    input [4:0]  modem;
    input [6:0]  ovr;
    input [2:0]  src;
    begin
      case (idx)
        `MTD_IDX_TONE_DC:    read_value = {24'h00_0000, tone_dc};
        `MTD_IDX_MODEM_TEST: read_value = {27'h000_0000, modem};
        `MTD_IDX_Q_OVERRIDE: read_value = {25'h000_0000, ovr};
        `MTD_IDX_DAC_SOURCE: read_value = {29'h0000_0000, src};
        default:             read_value = 32'h0000_0000;
      endcase
    end
  endfunction

  function is_mapped;
    input [15:0] idx;
    begin
      is_mapped = (idx == `MTD_IDX_TONE_DC) || (idx == `MTD_IDX_MODEM_TEST) ||
                  (idx == `MTD_IDX_Q_OVERRIDE) || (idx == `MTD_IDX_DAC_SOURCE);
    end
  endfunction

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  reg        aw_have_q;
  reg [15:0] aw_idx_q;
  reg        w_have_q;
  reg [7:0]  w_data_q;
  reg        w_lane0_q;
  wire       wr_fire;

  reg [7:0]  tone_dc_q;
  reg [4:0]  modem_test_q;
  reg [6:0]  q_override_q;
  reg [2:0]  dac_source_q;

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aw_have_q    <= 1'b0;
      aw_idx_q     <= 16'h0000;
      w_have_q     <= 1'b0;
      w_data_q     <= 8'h00;
      w_lane0_q    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MTD_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[17:2];
      end
      if (s_axi_wvalid && !w_have_q)
      begin
        w_have_q  <= 1'b1;
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_idx_q) ? `MTD_RESP_OKAY : `MTD_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `MTD_RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= read_value(s_axi_araddr[17:2], tone_dc_q, modem_test_q,
                                 q_override_q, dac_source_q);
      s_axi_rresp  <= is_mapped(s_axi_araddr[17:2]) ? `MTD_RESP_OKAY : `MTD_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Upper bits are never stored, so they cannot read back non-zero
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tone_dc_q    <= `MTD_RST_TONE_DC;
      modem_test_q <= `MTD_RST_MODEM_TEST;
      q_override_q <= `MTD_RST_Q_OVERRIDE;
      dac_source_q <= `MTD_RST_DAC_SOURCE;
    end
    else if (wr_fire && w_lane0_q)
    begin
      case (aw_idx_q)
        `MTD_IDX_TONE_DC:    tone_dc_q    <= w_data_q;
        `MTD_IDX_MODEM_TEST: modem_test_q <= w_data_q[4:0];
        `MTD_IDX_Q_OVERRIDE: q_override_q <= w_data_q[6:0];
        `MTD_IDX_DAC_SOURCE: dac_source_q <= w_data_q[2:0];
        default:             tone_dc_q    <= tone_dc_q;
      endcase
    end
  end

  // ****************************************************************
  // Receive DC blockers
  // ****************************************************************
  // Code 11 is left to behave like normal cancellation
  mtd_dc_blocker u_dc_i (
    .clock            (clock),
    .arst_n           (arst_n),
    .dc_blocker_op    (tone_dc_q[`MTD_DCOP_HI:`MTD_DCOP_LO]),
    .dc_window_length (tone_dc_q[`MTD_WIN_HI:`MTD_WIN_LO]),
    .sync_found       (rx_sync_found),
    .in_data          (rx_i_in),
    .in_valid         (rx_in_valid),
    .out_data         (rx_i_out),
    .out_valid        (rx_out_valid)
  );

  mtd_dc_blocker u_dc_q (
    .clock            (clock),
    .arst_n           (arst_n),
    .dc_blocker_op    (tone_dc_q[`MTD_DCOP_HI:`MTD_DCOP_LO]),
    .dc_window_length (tone_dc_q[`MTD_WIN_HI:`MTD_WIN_LO]),
    .sync_found       (rx_sync_found),
    .in_data          (rx_q_in),
    .in_valid         (rx_in_valid),
    .out_data         (rx_q_out),
    .out_valid        ()
  );

  // ****************************************************************
  // Transmit tone, modulation phase and ramp
  // ****************************************************************
  wire [6:0] tone_i;
  wire [6:0] tone_q;
  wire [6:0] mod_q_w;
  wire [6:0] tx_i_w;
  wire [6:0] tx_q_w;
  reg  [4:0] ramp_lvl_q;
  reg  [2:0] ramp_div_q;

  mtd_tone_gen u_tone (
    .clock     (clock),
    .arst_n    (arst_n),
    .step_code (tone_dc_q[`MTD_TONE_HI:`MTD_TONE_LO]),
    .tone_i    (tone_i),
    .tone_q    (tone_q)
  );

  // Reversed phase mirrors Q; -64 would overflow, so it clamps to +63
  assign mod_q_w = modem_test_q[`MTD_BIT_MODSEL] ?
                   ((mod_q_in == 7'h40) ? 7'h3f : (7'h00 - mod_q_in)) : mod_q_in;
  assign tx_i_w  = modem_test_q[`MTD_BIT_TONE_ONLY] ? tone_i :
                   sat_add7(mod_i_in, tone_i);
  assign tx_q_w  = modem_test_q[`MTD_BIT_TONE_ONLY] ? tone_q :
                   sat_add7(mod_q_w, tone_q);

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ramp_lvl_q <= 5'h00;
      ramp_div_q <= 3'h0;
    end
    else if (!modem_test_q[`MTD_BIT_RAMP])
    begin
      ramp_lvl_q <= tx_active ? `MTD_RAMP_FULL : 5'h00;
      ramp_div_q <= 3'h0;
    end
    else if (ramp_div_q == RAMP_CYC[2:0] - 3'h1)
    begin
      ramp_div_q <= 3'h0;
      if (tx_active && ramp_lvl_q != `MTD_RAMP_FULL)
        ramp_lvl_q <= ramp_lvl_q + 5'h01;
      else if (!tx_active && ramp_lvl_q != 5'h00)
        ramp_lvl_q <= ramp_lvl_q - 5'h01;
    end
    else
      ramp_div_q <= ramp_div_q + 3'h1;
  end

  // ****************************************************************
  // DAC source select
  // ****************************************************************
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dac_i_out         <= 7'h00;
      dac_q_out         <= 7'h00;
      mod_phase_reverse <= 1'b0;
    end
    else
    begin
      mod_phase_reverse <= modem_test_q[`MTD_BIT_MODSEL];
      dac_i_out <= 7'h00;
      case (dac_source_q)
        `MTD_SRC_MOD:
        begin
          dac_i_out <= scale7(tx_i_w, ramp_lvl_q);
          dac_q_out <= scale7(tx_q_w, ramp_lvl_q);
        end
        `MTD_SRC_OVR:    dac_q_out <= q_override_q;
        `MTD_SRC_ADC:    dac_q_out <= slice7(adc_q_word, q_override_q);
        `MTD_SRC_FILT:   dac_q_out <= slice7(filt_q_word, q_override_q);
        `MTD_SRC_CORDIC: dac_q_out <= slice7(cordic_word, q_override_q);
        `MTD_SRC_RSSI:
        begin
          dac_i_out <= rssi_word;
          dac_q_out <= 7'h00;
        end
        default:         dac_q_out <= 7'h00;
      endcase
    end
  end

  // ****************************************************************
  // Packet observation on GPIO
  // ****************************************************************
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gpio_observe_out <= 2'h0;
      gpio_observe_oe  <= 1'b0;
    end
    else
    begin
      gpio_observe_oe  <= modem_test_q[`MTD_BIT_OBSERVE];
      gpio_observe_out <= modem_test_q[`MTD_BIT_OBSERVE] ?
                          {tx_pkt_bit, rx_pkt_bit} : 2'h0;
    end
  end

endmodule // mtd_top

// ---- dv/mtd_properties.sv ----
`timescale 1ns/10ps
module mtd_properties (
  input wire        clock,
  input wire        arst_n,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        rx_in_valid,
  input wire        rx_out_valid,
  input wire        rx_pkt_bit,
  input wire        tx_pkt_bit,
  input wire [1:0]  gpio_observe_out,
  input wire        gpio_observe_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  AST_RX_VALID_ON: assert property (rx_in_valid |=> rx_out_valid)
    else $error("rx sample lost");
  AST_RX_VALID_OFF: assert property (!rx_in_valid |=> !rx_out_valid)
    else $error("rx output without sample");
  AST_OBS_IDLE: assert property (!gpio_observe_oe |-> gpio_observe_out == 2'h0)
    else $error("observe pins active while off");
  AST_OBS_COPY: assert property (gpio_observe_oe && $past(gpio_observe_oe)
    |-> gpio_observe_out == $past({tx_pkt_bit, rx_pkt_bit}))
    else $error("observe pins do not follow packet bits");
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
endmodule // mtd_properties

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
`include "mtd_reg_map.vh"
module tb_top;
  logic        clock = 1'b0, arst_n = 1'b0;
  logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = '0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, gpio_observe_out, rsp;
  logic [9:0]  rx_i_in = '0, rx_q_in = '0, rx_i_out, rx_q_out;
  logic        rx_in_valid = 1'b0, rx_sync_found = 1'b0, tx_active = 1'b0;
  logic        rx_pkt_bit = 1'b0, tx_pkt_bit = 1'b0;
  logic        rx_out_valid, mod_phase_reverse, gpio_observe_oe;
  logic [6:0]  mod_i_in = '0, mod_q_in = '0, rssi_word = '0, dac_i_out, dac_q_out, eq, ei;
  logic [11:0] adc_q_word = '0, filt_q_word = '0, cordic_word = '0, w;
  int          err_total = 0, comparisons = 0, seed = 32'hdc52, a;
  int          mdl [4] = '{`MTD_RST_TONE_DC, `MTD_RST_MODEM_TEST, 0, 0};
  logic [15:0] idx_t [5] = '{`MTD_IDX_TONE_DC, `MTD_IDX_MODEM_TEST, `MTD_IDX_Q_OVERRIDE,
                             `MTD_IDX_DAC_SOURCE, 16'h61bb};
  logic [7:0]  mask_t [4] = '{8'hff, 8'h1f, 8'h7f, 8'h07};

  mtd_top i_mtd_top (.clock, .arst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_i_in,
    .rx_q_in, .rx_in_valid, .rx_sync_found, .rx_i_out, .rx_q_out, .rx_out_valid,
    .mod_phase_reverse, .mod_i_in, .mod_q_in, .tx_active, .adc_q_word, .filt_q_word,
    .cordic_word, .rssi_word, .dac_i_out, .dac_q_out, .rx_pkt_bit, .tx_pkt_bit,
    .gpio_observe_out, .gpio_observe_oe);

  always #12.5 clock = ~clock;

  // **********
  // Bus and check helpers
  // **********
  task report_and_stop;
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tmo(input int n);
    if (n >= 40)
    begin
      err_total++;
      $display("mismatch at %0t: bus answer timed out", $time);
      report_and_stop;
    end
  endtask

  task wr(input logic [15:0] idx, input logic [7:0] v, input logic [3:0] st);
    int n;
    @(posedge clock);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {8'($random(seed)), 16'h0000, v};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      tmo(n);
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask

  task rdx(input logic [15:0] idx);
    int n;
    @(posedge clock);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      tmo(n);
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  // Unmapped index 4 must answer with an error and zero data
  task rchk(input int k);
    rdx(idx_t[k]);
    chk(rd, (k < 4) ? mdl[k] : 0);
    chk({30'h0, rsp}, {30'h0, (k < 4) ? `MTD_RESP_OKAY : `MTD_RESP_SLVERR});
  endtask

  task mwr(input int k, input logic [7:0] v);
    if (k == 1) v[0] = 1'b0;
    if (k == 0 && v[1:0] == 2'h3) v[1] = 1'b0;
    wr(idx_t[k], v, 4'hf);
    chk({30'h0, rsp}, {30'h0, (k < 4) ? `MTD_RESP_OKAY : `MTD_RESP_SLVERR});
    if (k < 4) mdl[k] = v & mask_t[k];
  endtask

  // Q carries the negated I stream so a swapped or shared path shows up
  task rx_run(input int n, input logic [9:0] v, input logic [9:0] est);
    repeat (n)
    begin
      @(posedge clock);
      rx_i_in <= v;
      rx_q_in <= -v;
      rx_in_valid <= 1'b1;
    end
    @(posedge clock);
    rx_in_valid <= 1'b0;
    @(negedge clock);
    chk({22'h0, rx_i_out}, {22'h0, v - est});
    chk({22'h0, rx_q_out}, {22'h0, est - v});
  endtask

  // **********
  // Main sequence
  // **********
  initial
  begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    for (int k = 0; k < 5; k++) rchk(k);
    for (int r = 0; r < 15; r++)
    begin
      mwr(r % 5, 8'($random(seed)));
      rchk(r % 5);
    end
    wr(idx_t[2], 8'h55, 4'h0);
    rchk(2);
    mwr(0, 8'h70);
    for (int i = 0; i < 16; i++) rx_run(1, 10'($random(seed)), 10'h000);
    mwr(0, 8'h7d);
    rx_run(100, 10'h028, 10'h000);
    rx_run(157, 10'h028, 10'h028);
    @(posedge clock);
    rx_sync_found <= 1'b1;
    mwr(0, 8'h72);
    rx_run(40, 10'h3e8, 10'h028);
    @(posedge clock);
    rx_sync_found <= 1'b0;
    rx_run(70, 10'h3e8, 10'h3e8);
    for (int s = 1; s < 6; s++)
      for (int q = 0; q < 16; q++)
      begin
        mwr(3, 8'(s));
        mwr(2, 8'(q));
        @(posedge clock);
        adc_q_word <= 12'($random(seed));
        filt_q_word <= 12'($random(seed));
        cordic_word <= 12'($random(seed));
        rssi_word <= 7'($random(seed));
        mod_i_in <= 7'($random(seed));
        mod_q_in <= 7'($random(seed));
        tx_active <= 1'($random(seed));
        @(posedge clock);
        @(negedge clock);
        w = (s == 2) ? adc_q_word : (s == 3) ? filt_q_word : cordic_word;
        eq = (s == 1) ? 7'(q) : (s > 4 || q < 6 || q > 11) ? 7'h00 : 7'(w >> (q - 6));
        ei = (s == 5) ? rssi_word : 7'h00;
        chk({25'h0, dac_q_out}, {25'h0, eq});
        chk({25'h0, dac_i_out}, {25'h0, ei});
      end
    for (int m = 0; m < 2; m++)
    begin
      mwr(1, m ? 8'h0e : 8'h08);
      repeat (8)
      begin
        @(posedge clock);
        rx_pkt_bit <= 1'($random(seed));
        tx_pkt_bit <= 1'($random(seed));
        @(posedge clock);
        @(negedge clock);
        chk({30'h0, gpio_observe_oe, mod_phase_reverse}, {30'h0, 1'(m), 1'(m)});
        chk({30'h0, gpio_observe_out}, {30'h0, m ? {tx_pkt_bit, rx_pkt_bit} : 2'h0});
      end
    end
    // Mid-run reset: defaults give a 0 Hz tone, ramping on, modulator source
    @(posedge clock);
    mod_i_in <= 7'($random(seed));
    mod_q_in <= 7'($random(seed));
    tx_active <= 1'b1;
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk({18'h0, dac_i_out, dac_q_out}, 32'h0);
    mdl = '{`MTD_RST_TONE_DC, `MTD_RST_MODEM_TEST, 0, 0};
    for (int k = 0; k < 4; k++) rchk(k);
    repeat (70) @(posedge clock);
    for (int m = 0; m < 3; m++)
    begin
      if (m > 0) mwr(1, (m == 1) ? 8'h0a : 8'h10);
      @(posedge clock);
      @(negedge clock);
      a = $signed(mod_i_in) + 63;
      ei = (m == 2 || a > 63) ? 7'h3f : 7'(a);
      eq = (m == 2) ? 7'h00 : (m == 0) ? mod_q_in :
           (mod_q_in == 7'h40) ? 7'h3f : 7'(-$signed(mod_q_in));
      chk({18'h0, dac_i_out, dac_q_out}, {18'h0, ei, eq});
    end
    // Ramping off: the amplitude must drop at once when transmission stops
    @(posedge clock);
    tx_active <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk({18'h0, dac_i_out, dac_q_out}, 32'h0);
    report_and_stop;
  end
endmodule // tb_top

bind mtd_top mtd_properties i_mtd_properties (.clock, .arst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_in_valid, .rx_out_valid,
  .rx_pkt_bit, .tx_pkt_bit, .gpio_observe_out, .gpio_observe_oe);
